// File: hw/plp_top.sv
// Program lock decode, code memory with encryption and verify path
//
// What this block does
// R01: Erase returns every code byte, encryption byte and lock bit to one.
// R02: With no lock bit programmed, nothing is restricted after the decode cycle; during reset and until then level three applies.
// R03: Verify data pass through the encryption array at every level that allows verify, even at level zero.
// R04: Level one blocks table reads from external code from seeing internal bytes.
// R05: Level one latches the external access pin at reset and ignores it afterwards.
// R06: Level one refuses further programming pulses.
// R07: Level two adds a block on verify readout.
// R08: Level three adds a block on external execution.
// R09: The programmer must only create the four defined lock combinations.
// R10: Verify uses six low address bits to pick an encryption byte, XNORed with code.
// R11: Lock bits have no direct readout; only their effects show.
// R12: A lock bit at zero is programmed, and the level is decoded at each reset.
`timescale 1ns/1ps
`default_nettype none
`include "plp_defines.svh"
module plp_top
   import plp_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    erase,
   input  wire logic                    program_pulse_pin,
   input  wire plp_target_t             program_pulse_pin_target,
   input  wire logic [1:0]              program_pulse_pin_lock_sel,
   input  wire logic [`PLP_CODE_AW-1:0] program_pulse_pin_addr,
   input  wire logic [7:0]              program_pulse_pin_data,
   input  wire logic                    verify_req,
   input  wire logic [`PLP_CODE_AW-1:0] verify_addr,
   output logic      [7:0]              verify_data,
   output logic                         verify_valid,
   input  wire logic                    external_access_pin,
   input  wire logic                    table_read_req,
   input  wire logic                    code_table_read_instr,
   input  wire logic                    exec_from_external,
   input  wire logic [`PLP_CODE_AW-1:0] table_read_addr,
   output logic      [7:0]              table_read_data,
   output logic                         table_read_valid,
   output logic                         table_read_denied,
   output logic                         ea_effective,
   output logic                         ext_exec_allowed,
   output logic                         program_pulse_pin_refused
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] pulse_sync_q;
   logic [1:0] ea_sync_q;
   logic       pulse_prev_q;
   logic       program_pulse_pin_pulse;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pulse_sync_q <= 2'h3;
         pulse_prev_q <= 1'b1;
      end
      else
      begin
         pulse_sync_q <= {pulse_sync_q[0], program_pulse_pin};
         pulse_prev_q <= pulse_sync_q[1];
      end
   end

   // Access pin sync runs through reset, so the decode cycle latches
   // the pin level as it stood during reset, not a reset constant
   always_ff @(posedge clk)
   begin
      ea_sync_q <= {ea_sync_q[0], external_access_pin};
   end

   // Programming happens on the falling edge of the active-low pulse
   assign program_pulse_pin_pulse = pulse_prev_q & ~pulse_sync_q[1];

   // ---------------------------------------------------------------
   // Lock bit cells and level decode
   // ---------------------------------------------------------------
   logic [2:0]  lock_cells_q;
   logic        decode_pending_q;
   plp_level_t  level_q;
   plp_prot_t   prot;
   logic        ea_latch_q;
   logic        program_pulse_pin_ok;
   logic        lock_bit_first;
   logic        lock_bit_second;
   logic        lock_bit_third;

   assign lock_bit_first  = ~lock_cells_q[`PLP_LOCK_FIRST];  // R12
   assign lock_bit_second = ~lock_cells_q[`PLP_LOCK_SECOND]; // R12
   assign lock_bit_third  = ~lock_cells_q[`PLP_LOCK_THIRD];  // R12

   assign program_pulse_pin_ok = program_pulse_pin_pulse & (level_q == PLP_LVL_NONE); // R06

   // Cells survive reset; only erase or a program pulse changes them
   always_ff @(posedge clk)
   begin
      if (erase)
         lock_cells_q <= `PLP_LOCK_ERASED; // R01
      else if (program_pulse_pin_ok && program_pulse_pin_target == PLP_TGT_LOCK && program_pulse_pin_lock_sel != 2'h3)
         lock_cells_q[program_pulse_pin_lock_sel] <= 1'b0;
   end

   // Decode once just after reset release, from stored cells
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         decode_pending_q <= 1'b1;
         level_q          <= PLP_LVL_THREE;
      end
      else if (erase)
      begin
         // Erase wins over a pending decode of the old cells
         decode_pending_q <= 1'b0;
         level_q          <= PLP_LVL_NONE; // R01
      end
      else if (decode_pending_q)
      begin
         decode_pending_q <= 1'b0;
         // Undefined combinations fall to the strongest matching prefix
         if (!lock_bit_first)
            level_q <= PLP_LVL_NONE; // R02
         else if (!lock_bit_second)
            level_q <= PLP_LVL_ONE;
         else if (!lock_bit_third)
            level_q <= PLP_LVL_TWO;
         else
            level_q <= PLP_LVL_THREE;
      end
   end

   // Pin is caught once at the decode cycle, held until next reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ea_latch_q <= 1'b0;
      else if (decode_pending_q)
         ea_latch_q <= ea_sync_q[1]; // R05
   end

   // Each level includes all protections of the one below
   always_comb
   begin
      prot.table_read_block = (level_q != PLP_LVL_NONE); // R04
      prot.ea_latched       = (level_q != PLP_LVL_NONE); // R05
      prot.program_pulse_pin_block       = (level_q != PLP_LVL_NONE); // R06
      prot.verify_block     = (level_q == PLP_LVL_TWO) || (level_q == PLP_LVL_THREE); // R07
      prot.ext_exec_block   = (level_q == PLP_LVL_THREE); // R08
   end

   assign ea_effective     = prot.ea_latched ? ea_latch_q : ea_sync_q[1]; // R05
   assign ext_exec_allowed = ~prot.ext_exec_block & ~decode_pending_q;    // R08

   // Flag a refused programming pulse for one cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         program_pulse_pin_refused <= 1'b0;
      else
         program_pulse_pin_refused <= program_pulse_pin_pulse & prot.program_pulse_pin_block; // R06
   end

   // ---------------------------------------------------------------
   // Code memory and encryption array
   // ---------------------------------------------------------------
   logic [7:0]              code_rd;
   logic [7:0]              enc_rd;
   logic [`PLP_CODE_AW-1:0] code_raddr;
   logic                    tr_sel;

   // Table reads share the port; verify wins if both arrive
   assign tr_sel     = table_read_req & ~verify_req;
   assign code_raddr = tr_sel ? table_read_addr : verify_addr;

   plp_mem #(.AW(`PLP_CODE_AW)) u_code (
      .clk   (clk),
      .erase (erase),
      .we    (program_pulse_pin_ok && program_pulse_pin_target == PLP_TGT_CODE),
      .waddr (program_pulse_pin_addr),
      .wdata (program_pulse_pin_data),
      .raddr (code_raddr),
      .rdata (code_rd)
   );

   plp_mem #(.AW(`PLP_ENC_AW)) u_enc (
      .clk   (clk),
      .erase (erase),
      .we    (program_pulse_pin_ok && program_pulse_pin_target == PLP_TGT_ENC),
      .waddr (program_pulse_pin_addr[`PLP_ENC_AW-1:0]),
      .wdata (program_pulse_pin_data),
      .raddr (verify_addr[`PLP_ENC_AW-1:0]), // R10
      .rdata (enc_rd)
   );

   // ---------------------------------------------------------------
   // Answer stage: one cycle after request
   // ---------------------------------------------------------------
   logic verify_q;
   logic tr_q;
   logic tr_deny;

   // External code asking for internal bytes is refused from level one up
   assign tr_deny = code_table_read_instr & exec_from_external & prot.table_read_block; // R04

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         verify_q          <= 1'b0;
         tr_q              <= 1'b0;
         table_read_denied <= 1'b0;
      end
      else
      begin
         verify_q          <= verify_req;
         tr_q              <= tr_sel & ~tr_deny;
         table_read_denied <= tr_sel & tr_deny;
      end
   end

   assign verify_valid     = verify_q;
   assign table_read_valid = tr_q;

   // Verify readout has no lock bit path; blocked output reads erased
   always_comb
   begin
      if (prot.verify_block)
         verify_data = `PLP_ERASED_BYTE; // R07 R11
      else
         verify_data = ~(code_rd ^ enc_rd); // R03 R10
   end

   // Data come from the memory register; zero when refused
   assign table_read_data = tr_q ? code_rd : 8'h00; // R04
endmodule
`default_nettype wire

// File: common/plp_defines.svh
// Constants for the program lock protection block
`ifndef PLP_DEFINES_SVH
`define PLP_DEFINES_SVH
`define PLP_CODE_AW       14
`define PLP_ENC_AW        6
`define PLP_ERASED_BYTE   8'hff
`define PLP_LOCK_ERASED   3'h7
`define PLP_LOCK_FIRST    0
`define PLP_LOCK_SECOND   1
`define PLP_LOCK_THIRD    2
`define PLP_CODE_WORDS    16384
`define PLP_ENC_WORDS     64
`endif

// File: common/plp_pkg.sv
// Types for the program lock protection block
`default_nettype none
package plp_pkg;
   typedef enum logic [1:0] {
      PLP_LVL_NONE,
      PLP_LVL_ONE,
      PLP_LVL_TWO,
      PLP_LVL_THREE
   } plp_level_t;

   typedef enum logic [1:0] {
      PLP_TGT_CODE,
      PLP_TGT_ENC,
      PLP_TGT_LOCK
   } plp_target_t;

   typedef struct packed {
      logic        table_read_block;
      logic        ea_latched;
      logic        program_pulse_pin_block;
      logic        verify_block;
      logic        ext_exec_block;
   } plp_prot_t;
endpackage
`default_nettype wire

// File: hw/plp_mem.sv
// Small synchronous memory, erased to all ones, registered read data
`timescale 1ns/1ps
`default_nettype none
module plp_mem #(
   parameter int AW = 6
) (
   input  wire logic          clk,
   input  wire logic          erase,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [7:0]    rdata
);
   logic [7:0] mem [0:(1<<AW)-1];

   // ---------------------------------------------------------------
   // Storage: erase sets every cell, programming only clears bits
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (erase)
      begin
         for (int i = 0; i < (1<<AW); i++)
            mem[i] <= 8'hff;
      end
      else if (we)
         mem[waddr] <= mem[waddr] & wdata; // Cells can only go 1 to 0
   end

   // Registered read port
   always_ff @(posedge clk)
   begin
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// File: tb/plp_props.sv
// Port checker for the program lock protection block
`timescale 1ns/1ps
`default_nettype none
module plp_props
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       erase,
   input wire logic       verify_req,
   input wire logic       verify_valid,
   input wire logic       table_read_req,
   input wire logic       code_table_read_instr,
   input wire logic       exec_from_external,
   input wire logic [7:0] table_read_data,
   input wire logic       table_read_valid,
   input wire logic       table_read_denied,
   input wire logic       ext_exec_allowed,
   input wire logic       program_pulse_pin_refused
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Request and answer pairing, one cycle apart
   property p_vfy_ans; verify_req |=> verify_valid; endproperty
   a_vfy_ans: assert property (p_vfy_ans) else $error("verify not answered");
   property p_vfy_only; !verify_req |=> !verify_valid; endproperty
   a_vfy_only: assert property (p_vfy_only) else $error("verify answer unasked");
   property p_vfy_wins; verify_req && table_read_req |=> !table_read_valid; endproperty
   a_vfy_wins: assert property (p_vfy_wins) else $error("table read not dropped");
   property p_tr_ans;
      table_read_req && !verify_req |=> table_read_valid != table_read_denied;
   endproperty
   a_tr_ans: assert property (p_tr_ans) else $error("table read answer wrong");
   // Denial only for table reads running from external code
   property p_tr_why;
      table_read_denied |-> $past(table_read_req && code_table_read_instr && exec_from_external);
   endproperty
   a_tr_why: assert property (p_tr_why) else $error("denied without cause");
   property p_tr_idle; !table_read_valid |-> table_read_data == 8'h00; endproperty
   a_tr_idle: assert property (p_tr_idle) else $error("table data leaks");
   // Erase frees the part at once, so external execution is allowed within two edges
   property p_erase_free; erase |-> ##[1:2] ext_exec_allowed; endproperty
   a_erase_free: assert property (p_erase_free) else $error("erase kept a block");
   // Level opens one edge after erase, the refusal flag one edge later
   property p_ref_pulse; erase |-> ##2 !program_pulse_pin_refused; endproperty
   a_ref_pulse: assert property (p_ref_pulse) else $error("refusal after erase");
   c_denied: cover property (table_read_denied);
   c_refused: cover property (program_pulse_pin_refused);
   c_blocked: cover property (!ext_exec_allowed ##1 erase);
endmodule
bind plp_top plp_props u_props (
   .clk(clk), .rst_n(rst_n), .erase(erase), .verify_req(verify_req),
   .verify_valid(verify_valid), .table_read_req(table_read_req),
   .code_table_read_instr(code_table_read_instr), .exec_from_external(exec_from_external),
   .table_read_data(table_read_data), .table_read_valid(table_read_valid),
   .table_read_denied(table_read_denied), .ext_exec_allowed(ext_exec_allowed),
   .program_pulse_pin_refused(program_pulse_pin_refused)
);
`default_nettype wire

// File: tb/plp_program_pulse_pin_model.sv
// Programmer model that issues program pulses
`timescale 1ns/1ps
`default_nettype none
`include "plp_defines.svh"
module plp_program_pulse_pin_model
   import plp_pkg::*;
(
   input  wire logic                   clk,
   output var  plp_target_t            target,
   output var  logic [1:0]             lock_sel,
   output var  logic [`PLP_CODE_AW-1:0] addr,
   output var  logic [7:0]             data,
   output var  logic                   pulse_n
);
   initial
   begin
      pulse_n  = 1'b1;
      target   = PLP_TGT_CODE;
      lock_sel = 2'h0;
      addr     = '0;
      data     = 8'h00;
   end
   // Low for four cycles to clear the pin sync; lines then inverted so
   // a stale address is never read as still held
   task automatic pulse(input plp_target_t t, input logic [1:0] s,
                        input logic [`PLP_CODE_AW-1:0] a, input logic [7:0] d);
      @(negedge clk);
      target   = t;
      lock_sel = s;
      addr     = a;
      data     = d;
      pulse_n  = 1'b0;
      repeat (4) @(negedge clk);
      pulse_n = 1'b1;
      repeat (4) @(negedge clk);
      addr = ~a;
      data = ~d;
   endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Testbench for the program lock protection block
`timescale 1ns/1ps
`default_nettype none
`include "plp_defines.svh"
module tb_top
   import plp_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, erase = 1'b0, vreq = 1'b0, treq = 1'b0;
   logic pin_n, ea_pin = 1'b1, instr = 1'b0, ext = 1'b0;
   logic vvalid, tvalid, tden, ea_eff, exec_ok, refused;
   logic [1:0] sel;
   logic [7:0] pdata, vdata, tdata;
   logic [`PLP_CODE_AW-1:0] paddr, vaddr = '0, taddr = 14'h0005;
   plp_target_t tgt;
   int error_cnt = 0, total_checks = 0, ref_cnt = 0;
   always #5 clk = ~clk;
   plp_program_pulse_pin_model pm (.clk(clk), .target(tgt), .lock_sel(sel), .addr(paddr),
                      .data(pdata), .pulse_n(pin_n));
   plp_top uut (.clk(clk), .rst_n(rst_n), .erase(erase), .program_pulse_pin(pin_n),
      .program_pulse_pin_target(tgt), .program_pulse_pin_lock_sel(sel), .program_pulse_pin_addr(paddr), .program_pulse_pin_data(pdata),
      .verify_req(vreq), .verify_addr(vaddr), .verify_data(vdata), .verify_valid(vvalid),
      .external_access_pin(ea_pin), .table_read_req(treq), .code_table_read_instr(instr),
      .exec_from_external(ext), .table_read_addr(taddr), .table_read_data(tdata),
      .table_read_valid(tvalid), .table_read_denied(tden), .ea_effective(ea_eff),
      .ext_exec_allowed(exec_ok), .program_pulse_pin_refused(refused));
   // Refusals are single-cycle pulses, so count them as they pass
   always @(negedge clk) if (refused === 1'b1) ref_cnt++;
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rst;
      rst_n = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask
   task automatic ers;
      erase = 1'b1;
      @(negedge clk);
      erase = 1'b0;
      @(negedge clk);
   endtask
   task automatic vfy(input logic [13:0] a, input logic [7:0] e);
      vreq  = 1'b1;
      vaddr = a;
      @(negedge clk);
      vreq = 1'b0;
      chk("verify_valid", 8'h01, {7'h0, vvalid});
      chk("verify_data", e, vdata);
      // Let an idle edge pass so back-to-back calls never retoggle vreq
      @(negedge clk);
   endtask
   task automatic trd(input logic i, input logic x, input logic v, input logic [7:0] e);
      treq  = 1'b1;
      instr = i;
      ext   = x;
      @(negedge clk);
      treq = 1'b0;
      chk("table_read_valid", {7'h0, v}, {7'h0, tvalid});
      chk("table_read_denied", {7'h0, ~v}, {7'h0, tden});
      chk("table_read_data", e, tdata);
      @(negedge clk);
   endtask
   // Erased part: open, code and key all ones, pin followed live
   task automatic t_erased;
      ers();
      rst();
      vfy(14'h0005, 8'hff);
      trd(1'b1, 1'b1, 1'b1, 8'hff);
      chk("ext_exec_allowed", 8'h01, {7'h0, exec_ok});
      ea_pin = 1'b0;
      repeat (4) @(negedge clk);
      chk("ea_effective", 8'h00, {7'h0, ea_eff});
      ea_pin = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   // Key byte 5 also masks address 45h, the low six bits select it
   task automatic t_encrypt;
      pm.pulse(PLP_TGT_CODE, 2'h0, 14'h0005, 8'h3c);
      pm.pulse(PLP_TGT_ENC, 2'h0, 14'h0005, 8'ha5);
      vfy(14'h0005, 8'h66);
      vfy(14'h0045, 8'ha5);
      vreq = 1'b1;
      treq = 1'b1;
      @(negedge clk);
      {vreq, treq} = 2'b00;
      chk("table_read_valid", 8'h00, {7'h0, tvalid});
      chk("refusals", 8'h00, ref_cnt[7:0]);
   endtask
   task automatic t_level1;
      pm.pulse(PLP_TGT_LOCK, 2'h0, 14'h0000, 8'h00);
      trd(1'b1, 1'b1, 1'b1, 8'h3c);
      rst();
      trd(1'b1, 1'b1, 1'b0, 8'h00);
      trd(1'b1, 1'b0, 1'b1, 8'h3c);
      ea_pin = 1'b0;
      repeat (5) @(negedge clk);
      chk("ea_effective", 8'h01, {7'h0, ea_eff});
      ea_pin = 1'b1;
      pm.pulse(PLP_TGT_CODE, 2'h0, 14'h0005, 8'h00);
      repeat (4) @(negedge clk);
      chk("refusals", 8'h01, ref_cnt[7:0]);
      vfy(14'h0005, 8'h66);
   endtask
   // Levels two and three: locks set while open, active after reset
   task automatic t_upper;
      ers();
      rst();
      pm.pulse(PLP_TGT_CODE, 2'h0, 14'h0005, 8'h3c);
      pm.pulse(PLP_TGT_LOCK, 2'h0, 14'h0000, 8'h00);
      pm.pulse(PLP_TGT_LOCK, 2'h1, 14'h0000, 8'h00);
      rst();
      vfy(14'h0005, 8'hff);
      trd(1'b1, 1'b1, 1'b0, 8'h00);
      chk("ext_exec_allowed", 8'h01, {7'h0, exec_ok});
      ers();
      rst();
      for (int b = 0; b < 3; b++) pm.pulse(PLP_TGT_LOCK, b[1:0], 14'h0000, 8'h00);
      rst();
      chk("ext_exec_allowed", 8'h00, {7'h0, exec_ok});
      ers();
      chk("ext_exec_allowed", 8'h01, {7'h0, exec_ok});
      vfy(14'h0005, 8'hff);
   endtask
   initial
   begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      t_erased();
      t_encrypt();
      t_level1();
      t_upper();
      stop_test();
   end
   // Guard against a hang anywhere in the sequence
   initial
   begin
      #500us;
      error_cnt++;
      stop_test();
   end
endmodule
`default_nettype wire
